/* File: rtl/ecf_fault_check.sv */
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
// What this block does
// RQ1: Lock, 66H, repeat, vector prefix give invalid opcode.
// RQ2: User op needs privilege level 3.
// RQ3: User op needs base feature bit 0.
// RQ4: System management mode gives invalid opcode.
// RQ5: Feature lock or enable clear gives protection fault.
// RQ6: Unsupported leaf index gives protection fault.
// RQ7: Enter or resume inside enclave faults.
// RQ8: Enclave-only leaves outside enclave fault.
// RQ9: User op faults on 16-bit code or data.
// RQ10: User op needs paging and numeric error bit.
// RQ11: Task switched bit gives device unavailable fault.
// RQ12: Hypervisor op selects leaf from accumulator.
// RQ13: Outside 64-bit, upper accumulator half ignored.
// RQ14: Hypervisor op needs protection, virtualization, no v86.
// RQ15: Long mode with 32-bit code faults.
// RQ16: Hypervisor op needs privilege level 0.
// RQ17: Hypervisor op needs oversubscription bit 5.
// RQ18: Guest needs execution enable else invalid opcode.
// RQ19: Guest exits when leaf bitmap bit set.
// RQ20: Hypervisor op needs paging enabled.
// RQ21: Expand-down data segment faults outside 64-bit.
// RQ22: Operand width follows 64-bit mode, not default size.
// RQ23: Segment, address-size, extension prefixes ignored.
// RQ24: Real and v86 mode give invalid opcode.
// RQ25: Checks run abort, mode, guest, protection order.
module ecf_fault_check
	import ecf_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic REQ_VALID,
	input wire ecf_req_t REQ,
	output logic RSP_VALID,
	output ecf_rsp_t RSP
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		ecf_bus_st_t st;
		logic wr;
		logic [7:0] addr;
		logic [31:0] hrdata;
		logic [3:0] ctrl;
		logic [5:0] cap;
		logic [63:0] bitmap;
		logic [31:0] user_mask;
		logic [31:0] hyp_mask;
		logic rsp_valid;
		ecf_rsp_t rsp;
		logic [15:0] faults;
	} ecf_state_t;

	ecf_state_t s;
	ecf_state_t next_s;

	// ----------------------------------------
	// Leaf select
	// ----------------------------------------
	logic in_64;
	logic wide_leaf;
	logic [31:0] leaf_mask;
	logic [63:0] leaf;
	logic supported;
	logic exit_bit;

	// Default-size bit of the code segment plays no part here
	assign in_64 = REQ.long_mode_active && REQ.cs_l; // RQ22
	// The user op always drops the upper accumulator half
	assign wide_leaf = REQ.hyp_op && in_64; // RQ13
	// Each op has its own table of supported leaves
	assign leaf_mask = REQ.hyp_op ? s.hyp_mask : s.user_mask; // RQ6

	ecf_leaf_sel u_leaf_sel (
		.rax(REQ.rax),
		.use_64(wide_leaf),
		.mask(leaf_mask),
		.bitmap(s.bitmap),
		.leaf(leaf),
		.supported(supported),
		.exit_bit(exit_bit)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		ecf_kind_t k;
		logic bad_pfx;
		logic feat_off;
		logic in_encl_leaf;
		logic outer_leaf;
		logic mode_off;
		logic compat_32;
		logic seg_16;
		logic counted;
		k = ECF_K_PROCEED;
		bad_pfx = 1'b0;
		feat_off = 1'b0;
		in_encl_leaf = 1'b0;
		outer_leaf = 1'b0;
		mode_off = 1'b0;
		compat_32 = 1'b0;
		seg_16 = 1'b0;
		counted = 1'b0;
		next_s = s;
		next_s.rsp_valid = 1'b0;

		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		// Write data phase lands before the read mux below
		if (s.st == ECF_BUS_DATA && s.wr) begin
			case (s.addr)
				ECF_OFS_CTRL: begin
					next_s.ctrl = HWDATA[3:0];
				end
				ECF_OFS_CAP: begin
					next_s.cap = HWDATA[5:0];
				end
				ECF_OFS_BMP_LO: begin
					next_s.bitmap[31:0] = HWDATA;
				end
				ECF_OFS_BMP_HI: begin
					next_s.bitmap[63:32] = HWDATA;
				end
				ECF_OFS_USER_MASK: begin
					next_s.user_mask = HWDATA;
				end
				ECF_OFS_HYP_MASK: begin
					next_s.hyp_mask = HWDATA;
				end
				default: begin
				end
			endcase
		end

		// ----------------------------------------
		// Register reads
		// ----------------------------------------
		// Address phase; no wait states, so read data is caught here
		if (HSEL && HTRANS[1] && HREADY) begin
			next_s.st = ECF_BUS_DATA;
			next_s.wr = HWRITE;
			next_s.addr = {HADDR[7:2], 2'h0};
			next_s.hrdata = 32'h0000_0000;
			if (!HWRITE) begin
				case ({HADDR[7:2], 2'h0})
					ECF_OFS_CTRL: begin
						next_s.hrdata = {28'h0, next_s.ctrl};
					end
					ECF_OFS_CAP: begin
						next_s.hrdata = {26'h0, next_s.cap};
					end
					ECF_OFS_BMP_LO: begin
						next_s.hrdata = next_s.bitmap[31:0];
					end
					ECF_OFS_BMP_HI: begin
						next_s.hrdata = next_s.bitmap[63:32];
					end
					ECF_OFS_USER_MASK: begin
						next_s.hrdata = next_s.user_mask;
					end
					ECF_OFS_HYP_MASK: begin
						next_s.hrdata = next_s.hyp_mask;
					end
					ECF_OFS_STATUS: begin
						next_s.hrdata = {s.rsp.leaf[15:0], 12'h0,
							s.rsp.wide_64, s.rsp.kind};
					end
					ECF_OFS_FAULTS: begin
						next_s.hrdata = {16'h0, s.faults};
					end
					default: begin
					end
				endcase
			end
		end else begin
			next_s.st = ECF_BUS_IDLE;
			next_s.wr = 1'b0;
			// Nothing stands on the read bus between transfers
			next_s.hrdata = 32'h0000_0000;
		end

		// ----------------------------------------
		// Fault checks
		// ----------------------------------------
		// Only these four prefixes fault; segment, address-size and
		// extension prefixes never reach this block
		bad_pfx = REQ.pfx_lock || REQ.pfx_opsize || REQ.pfx_rep
			|| REQ.pfx_vex; // RQ1 RQ23
		// Real-address and virtual-8086 code never sees either op
		mode_off = !REQ.prot_en || REQ.v86; // RQ14 RQ24
		// Long mode running a 32-bit code segment
		compat_32 = REQ.long_mode_active && !REQ.cs_l; // RQ15
		seg_16 = !REQ.cs_d || !REQ.ds_b; // RQ9
		feat_off = !s.ctrl[ECF_CTRL_LOCK]
			|| !s.ctrl[ECF_CTRL_ENCL_EN]; // RQ5
		in_encl_leaf = (leaf[31:0] == ECF_LEAF_ENTER)
			|| (leaf[31:0] == ECF_LEAF_RESUME);
		outer_leaf = (leaf[31:0] == ECF_LEAF_REPORT)
			|| (leaf[31:0] == ECF_LEAF_KEY)
			|| (leaf[31:0] == ECF_LEAF_EXIT)
			|| (leaf[31:0] == ECF_LEAF_ACCEPT)
			|| (leaf[31:0] == ECF_LEAF_PERM_EXT)
			|| (leaf[31:0] == ECF_LEAF_ACCEPT_COPY);

		if (REQ.hyp_op) begin
			// Order matters: a guest exit must beat protection faults
			if (REQ.tsx_active) begin
				k = ECF_K_ABORT; // RQ25
			end else if (bad_pfx) begin
				k = ECF_K_UD; // RQ1
			end else if (mode_off) begin
				k = ECF_K_UD; // RQ14 RQ24
			end else if (REQ.system_management_mode) begin
				k = ECF_K_UD; // RQ4
			end else if (!s.cap[ECF_CAP_OVERSUB]) begin
				k = ECF_K_UD; // RQ17
			end else if (!REQ.vmx_op) begin
				k = ECF_K_UD; // RQ14
			end else if (compat_32) begin
				k = ECF_K_UD; // RQ15
			end else if (REQ.current_privilege_level != ECF_CPL_KERNEL) begin
				k = ECF_K_UD; // RQ16
			end else if (REQ.non_root && !s.ctrl[ECF_CTRL_GUEST_EXEC]) begin
				k = ECF_K_UD; // RQ18
			end else if (REQ.non_root && s.ctrl[ECF_CTRL_GUEST_EXIT]
				&& exit_bit) begin
				k = ECF_K_EXIT; // RQ19
			end else if (feat_off) begin
				k = ECF_K_GP; // RQ5
			end else if (!supported) begin
				k = ECF_K_GP; // RQ6 RQ12
			end else if (!REQ.paging_en) begin
				k = ECF_K_GP; // RQ20
			end else if (!in_64 && REQ.ds_expand_down) begin
				k = ECF_K_GP; // RQ21
			end else begin
				k = ECF_K_PROCEED; // RQ25
			end
		end else begin
			// Device-unavailable ranks below feature bit, above privilege
			if (REQ.tsx_active) begin
				k = ECF_K_ABORT; // RQ25
			end else if (bad_pfx) begin
				k = ECF_K_UD; // RQ1
			end else if (mode_off) begin
				k = ECF_K_UD; // RQ24
			end else if (REQ.system_management_mode) begin
				k = ECF_K_UD; // RQ4
			end else if (!s.cap[ECF_CAP_BASE]) begin
				k = ECF_K_UD; // RQ3
			end else if (REQ.task_sw) begin
				k = ECF_K_NM; // RQ11
			end else if (REQ.current_privilege_level != ECF_CPL_USER) begin
				k = ECF_K_UD; // RQ2
			end else if (feat_off) begin
				k = ECF_K_GP; // RQ5
			end else if (!supported) begin
				k = ECF_K_GP; // RQ6
			end else if (!REQ.numeric_err) begin
				k = ECF_K_GP; // RQ10
			end else if (!in_64 && !REQ.paging_en) begin
				k = ECF_K_GP; // RQ10
			end else if (!in_64 && seg_16) begin
				k = ECF_K_GP; // RQ9
			end else if (REQ.enclave_mode && in_encl_leaf) begin
				k = ECF_K_GP; // RQ7
			end else if (!REQ.enclave_mode && outer_leaf) begin
				k = ECF_K_GP; // RQ8
			end else begin
				k = ECF_K_PROCEED;
			end
		end

		// ----------------------------------------
		// Answer
		// ----------------------------------------
		if (REQ_VALID) begin
			next_s.rsp_valid = 1'b1;
			next_s.rsp.kind = k;
			next_s.rsp.err_code = ECF_ERR_ZERO; // RQ5
			next_s.rsp.leaf = leaf; // RQ12
			// Default-size bit plays no part in the width
			next_s.rsp.wide_64 = in_64; // RQ22
			counted = (k != ECF_K_PROCEED);
			// Counter saturates so software never sees a wrap
			if (counted && s.faults != ECF_FAULTS_MAX) begin
				next_s.faults = s.faults + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s.st <= ECF_BUS_IDLE;
			s.wr <= 1'b0;
			s.addr <= 8'h00;
			s.hrdata <= 32'h0000_0000;
			s.ctrl <= ECF_CTRL_RST;
			s.cap <= ECF_CAP_RST;
			s.bitmap <= ECF_BMP_RST;
			s.user_mask <= ECF_USER_MASK_RST;
			s.hyp_mask <= ECF_HYP_MASK_RST;
			s.rsp_valid <= 1'b0;
			s.rsp.kind <= ECF_K_PROCEED;
			s.rsp.err_code <= ECF_ERR_ZERO;
			s.rsp.leaf <= 64'h0000_0000_0000_0000;
			s.rsp.wide_64 <= 1'b0;
			s.faults <= 16'h0000;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign HRDATA = s.hrdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign RSP_VALID = s.rsp_valid;
	assign RSP = s.rsp;

endmodule : ecf_fault_check

/* File: rtl/ecf_leaf_sel.sv */
`timescale 1ns/100ps
module ecf_leaf_sel
	import ecf_pkg::*;
(
	input wire logic [63:0] rax,
	input wire logic use_64,
	input wire logic [31:0] mask,
	input wire logic [63:0] bitmap,
	output logic [63:0] leaf,
	output logic supported,
	output logic exit_bit
);

	logic below_last;

	always_comb begin
		leaf = use_64 ? rax : {32'h0000_0000, rax[31:0]}; // RQ13
		supported = (leaf[63:5] == 59'h0) && mask[leaf[4:0]]; // RQ6
		below_last = (leaf[63:6] == 58'h0) && (leaf[5:0] != ECF_BMP_LAST);
		// Leaves from 63 upward share the top bit
		exit_bit = below_last ? bitmap[leaf[5:0]] : bitmap[ECF_BMP_LAST]; // RQ19
	end

endmodule : ecf_leaf_sel

/* File: rtl/ecf_pkg.sv */
package ecf_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ECF_OFS_CTRL = 8'h00;
	localparam logic [7:0] ECF_OFS_CAP = 8'h04;
	localparam logic [7:0] ECF_OFS_BMP_LO = 8'h08;
	localparam logic [7:0] ECF_OFS_BMP_HI = 8'h0C;
	localparam logic [7:0] ECF_OFS_USER_MASK = 8'h10;
	localparam logic [7:0] ECF_OFS_HYP_MASK = 8'h14;
	localparam logic [7:0] ECF_OFS_STATUS = 8'h18;
	localparam logic [7:0] ECF_OFS_FAULTS = 8'h1C;

	// CTRL fields
	localparam int ECF_CTRL_LOCK = 0;
	localparam int ECF_CTRL_ENCL_EN = 1;
	localparam int ECF_CTRL_GUEST_EXEC = 2;
	localparam int ECF_CTRL_GUEST_EXIT = 3;
	// CAP fields
	localparam int ECF_CAP_BASE = 0;
	localparam int ECF_CAP_OVERSUB = 5;

	localparam logic [3:0] ECF_CTRL_RST = 4'h0;
	localparam logic [5:0] ECF_CAP_RST = 6'h21;
	localparam logic [63:0] ECF_BMP_RST = 64'h0000_0000_0000_0000;
	localparam logic [31:0] ECF_USER_MASK_RST = 32'h0000_00FF;
	localparam logic [31:0] ECF_HYP_MASK_RST = 32'h0000_0003;

	// ----------------------------------------
	// User leaf indices
	// ----------------------------------------
	localparam logic [31:0] ECF_LEAF_REPORT = 32'h0000_0000;
	localparam logic [31:0] ECF_LEAF_KEY = 32'h0000_0001;
	localparam logic [31:0] ECF_LEAF_ENTER = 32'h0000_0002;
	localparam logic [31:0] ECF_LEAF_RESUME = 32'h0000_0003;
	localparam logic [31:0] ECF_LEAF_EXIT = 32'h0000_0004;
	localparam logic [31:0] ECF_LEAF_ACCEPT = 32'h0000_0005;
	localparam logic [31:0] ECF_LEAF_PERM_EXT = 32'h0000_0006;
	localparam logic [31:0] ECF_LEAF_ACCEPT_COPY = 32'h0000_0007;

	localparam logic [1:0] ECF_CPL_USER = 2'h3;
	localparam logic [1:0] ECF_CPL_KERNEL = 2'h0;
	localparam logic [15:0] ECF_ERR_ZERO = 16'h0000;
	localparam logic [5:0] ECF_BMP_LAST = 6'h3F;
	localparam logic [15:0] ECF_FAULTS_MAX = 16'hFFFF;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ECF_K_PROCEED = 3'h0,
		ECF_K_UD = 3'h1,
		ECF_K_GP = 3'h2,
		ECF_K_NM = 3'h3,
		ECF_K_EXIT = 3'h4,
		ECF_K_ABORT = 3'h5
	} ecf_kind_t;

	typedef enum logic [1:0] {
		ECF_BUS_IDLE = 2'h1,
		ECF_BUS_DATA = 2'h2
	} ecf_bus_st_t;

	typedef struct packed {
		logic hyp_op;
		logic pfx_lock;
		logic pfx_opsize;
		logic pfx_rep;
		logic pfx_vex;
		logic [1:0] current_privilege_level;
		logic prot_en;
		logic paging_en;
		logic numeric_err;
		logic task_sw;
		logic v86;
		logic system_management_mode;
		logic tsx_active;
		logic vmx_op;
		logic non_root;
		logic long_mode_active;
		logic cs_l;
		logic cs_d;
		logic ds_b;
		logic ds_expand_down;
		logic enclave_mode;
		logic [63:0] rax;
	} ecf_req_t;

	typedef struct packed {
		ecf_kind_t kind;
		logic [15:0] err_code;
		logic [63:0] leaf;
		logic wide_64;
	} ecf_rsp_t;

endpackage : ecf_pkg

/* File: verification/ecf_fault_check_assertions.sv */
`timescale 1ns/100ps
module ecf_chk
	import ecf_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic REQ_VALID,
	input wire ecf_req_t REQ,
	input wire logic RSP_VALID,
	input wire ecf_rsp_t RSP
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	logic ok, pfx, q_w, q_h;
	logic [63:0] q_rax;
	assign ok = REQ_VALID && !REQ.tsx_active;
	assign pfx = REQ.pfx_lock | REQ.pfx_opsize | REQ.pfx_rep | REQ.pfx_vex;
	// Context of the request that the next answer belongs to
	always_ff @(posedge CLK) begin
		q_w <= REQ.long_mode_active & REQ.cs_l;
		q_h <= REQ.hyp_op;
		q_rax <= REQ.rax;
	end
	answer_pulse_a: assert property (RSP_VALID == $past(REQ_VALID))
		else $error("answer pulse out of step");
	answer_hold_a: assert property (!REQ_VALID |=> $stable(RSP))
		else $error("answer changed without request");
	abort_kind_a: assert property (REQ_VALID && REQ.tsx_active |=>
		RSP.kind == ECF_K_ABORT) else $error("abort not reported");
	prefix_ud_a: assert property (ok && pfx |=> RSP.kind == ECF_K_UD)
		else $error("prefix not refused");
	mode_ud_a: assert property (ok && (REQ.system_management_mode || !REQ.prot_en ||
		REQ.v86) |=> RSP.kind == ECF_K_UD) else $error("mode not refused");
	hyp_ud_a: assert property (ok && REQ.hyp_op && (REQ.current_privilege_level != 2'h0 ||
		!REQ.vmx_op || REQ.long_mode_active && !REQ.cs_l) |=>
		RSP.kind == ECF_K_UD) else $error("hypervisor op not refused");
	user_cpl_a: assert property (ok && !REQ.hyp_op && !REQ.task_sw &&
		REQ.current_privilege_level != 2'h3 |=> RSP.kind == ECF_K_UD) else $error("user cpl");
	err_zero_a: assert property (RSP_VALID |-> RSP.err_code == 16'h0)
		else $error("error code not zero");
	operand_width_a: assert property (RSP_VALID |-> RSP.wide_64 == q_w)
		else $error("operand width wrong");
	leaf_value_a: assert property (RSP_VALID |-> RSP.leaf ==
		(q_w && q_h ? q_rax : {32'h0, q_rax[31:0]})) else $error("leaf");
endmodule : ecf_chk
bind ecf_fault_check ecf_chk chk (.CLK, .RST_N, .REQ_VALID, .REQ,
	.RSP_VALID, .RSP);

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
	import ecf_pkg::*;
	logic CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
	logic REQ_VALID = 1'b0, HREADYOUT, HRESP, RSP_VALID;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd, fc;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h0;
	ecf_req_t REQ = '0, u, h;
	ecf_rsp_t RSP;
	int miscompares = 0, checked = 0, cyc = 0;
	logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
	logic [31:0] rv [7] = '{32'h0, 32'h21, 32'h0, 32'h0, 32'hFF, 32'h3, 32'h0};
	ecf_fault_check DUT (.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
		.HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT,
		.HRESP, .REQ_VALID, .REQ, .RSP_VALID, .RSP);
	initial forever #5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			results();
		end
	end
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// ----------------------------------------
	// Bus and check port drivers
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HSIZE <= 3'h2;
		HADDR <= {24'h0, a};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		cmp(HRESP, 64'h0);
	endtask : bus
	task automatic run(input ecf_req_t b, input int f, input ecf_kind_t k);
		ecf_req_t r;
		r = b;
		case (f)
			0: r.pfx_lock = 1'b1;
			1: r.pfx_opsize = 1'b1;
			2: r.pfx_rep = 1'b1;
			3: r.pfx_vex = 1'b1;
			4: r.system_management_mode = 1'b1;
			5: r.current_privilege_level = 2'h1;
			6: r.task_sw = 1'b1;
			7: r.prot_en = 1'b0;
			8: r.v86 = 1'b1;
			9: r.paging_en = 1'b0;
			10: r.numeric_err = 1'b0;
			11: r.cs_d = 1'b0;
			12: r.ds_b = 1'b0;
			13: r.enclave_mode = 1'b1;
			14: r.vmx_op = 1'b0;
			15: r.cs_l = 1'b0;
			16: r.ds_expand_down = 1'b1;
			17: r.tsx_active = 1'b1;
			default: ;
		endcase
		REQ <= r;
		REQ_VALID <= 1'b1;
		@(posedge CLK);
		REQ_VALID <= 1'b0;
		@(posedge CLK);
		cmp(RSP_VALID, 64'h1);
		cmp(RSP.kind, k);
		cmp(RSP.wide_64, r.long_mode_active & r.cs_l);
	endtask : run
	task automatic results();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	initial begin
		u = '0;
		u.current_privilege_level = ECF_CPL_USER;
		u.prot_en = 1'b1;
		u.paging_en = 1'b1;
		u.numeric_err = 1'b1;
		u.cs_d = 1'b1;
		u.ds_b = 1'b1;
		u.rax = {32'h0, ECF_LEAF_ENTER};
		h = '0;
		h.hyp_op = 1'b1;
		h.prot_en = 1'b1;
		h.paging_en = 1'b1;
		h.vmx_op = 1'b1;
		h.long_mode_active = 1'b1;
		h.cs_l = 1'b1;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		foreach (ofs[i]) begin
			bus(1'b1, 8'h20, 32'hFFFF_FFFF);
			bus(1'b0, ofs[i], 32'h0);
			cmp(rd, rv[i]);
		end
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ECF_OFS_CTRL, i);
			run(u, 99, i == 3 ? ECF_K_PROCEED : ECF_K_GP);
		end
		for (int i = 0; i < 5; i++) run(u, i, ECF_K_UD);
		run(u, 5, ECF_K_UD);
		run(u, 6, ECF_K_NM);
		run(u, 8, ECF_K_UD);
		run(u, 9, ECF_K_GP);
		run(u, 10, ECF_K_GP);
		run(u, 11, ECF_K_GP);
		run(u, 12, ECF_K_GP);
		run(u, 13, ECF_K_GP);
		run(u, 17, ECF_K_ABORT);
		u.rax = {32'h0, ECF_LEAF_RESUME};
		run(u, 13, ECF_K_GP);
		u.rax = {32'h0, ECF_LEAF_KEY};
		run(u, 99, ECF_K_GP);
		run(u, 13, ECF_K_PROCEED);
		u.rax = 64'h8;
		run(u, 99, ECF_K_GP);
		u.rax = {32'h0, ECF_LEAF_ENTER};
		u.long_mode_active = 1'b1;
		u.cs_l = 1'b1;
		run(u, 9, ECF_K_PROCEED);
		run(u, 11, ECF_K_PROCEED);
		run(u, 10, ECF_K_GP);
		bus(1'b1, ECF_OFS_CAP, 32'h20);
		run(u, 99, ECF_K_UD);
		bus(1'b1, ECF_OFS_CAP, 32'h01);
		run(h, 99, ECF_K_UD);
		bus(1'b1, ECF_OFS_CAP, 32'h21);
		$display("test user op done");
		run(h, 99, ECF_K_PROCEED);
		for (int i = 0; i < 5; i++) run(h, i, ECF_K_UD);
		run(h, 5, ECF_K_UD);
		run(h, 7, ECF_K_UD);
		run(h, 8, ECF_K_UD);
		run(h, 14, ECF_K_UD);
		run(h, 15, ECF_K_UD);
		run(h, 9, ECF_K_GP);
		run(h, 16, ECF_K_PROCEED);
		run(h, 17, ECF_K_ABORT);
		h.long_mode_active = 1'b0;
		h.rax = 64'hFFFF_0000_0000_0001;
		run(h, 11, ECF_K_PROCEED);
		cmp(RSP.leaf, 64'h1);
		run(h, 16, ECF_K_GP);
		h.long_mode_active = 1'b1;
		h.non_root = 1'b1;
		h.rax = 64'h1_0000_0000;
		run(h, 99, ECF_K_UD);
		bus(1'b1, ECF_OFS_CTRL, 32'h7);
		bus(1'b1, ECF_OFS_BMP_HI, 32'h8000_0000);
		run(h, 99, ECF_K_GP);
		bus(1'b1, ECF_OFS_CTRL, 32'hF);
		run(h, 99, ECF_K_EXIT);
		cmp(RSP.leaf, 64'h1_0000_0000);
		h.rax = 64'h1;
		run(h, 99, ECF_K_PROCEED);
		bus(1'b1, ECF_OFS_BMP_LO, 32'h2);
		run(h, 99, ECF_K_EXIT);
		bus(1'b0, ECF_OFS_STATUS, 32'h0);
		cmp(rd, 32'h0001_000C);
		bus(1'b0, ECF_OFS_FAULTS, 32'h0);
		fc = rd;
		run(h, 99, ECF_K_EXIT);
		h.rax = 64'h0;
		run(h, 99, ECF_K_PROCEED);
		bus(1'b0, ECF_OFS_FAULTS, 32'h0);
		cmp(rd, fc + 32'h1);
		$display("test hypervisor op done");
		results();
	end
endmodule : tb
